// *** core/ccr_pkg.sv ***
// Constants, register map and rate helpers for the codec clock and rate control block.
// Functional notes
// [R01] Core clock comes from a divider fed by the PLL or the external clock pin.
// [R02] Core clock always runs at 256 times the base sampling frequency.
// [R03] With the PLL selected (1024x) the divider is forced to divide by four.
// [R04] Divider follows input rate: 256x /1, 512x /2, 768x /3, 1024x /4.
// [R05] Clock control bit 3 picks the source: 0 external pin (default), 1 PLL.
// [R06] Host sets bits 2:1 to the input rate: 00 256x, 01 512x, 10 768x, 11 1024x.
// [R07] Clock control bit 0 enables the core clock; reset leaves it disabled.
// [R08] Converter, serial port and processing core clocks all derive from the core clock.
// [R09] Converters run at a rate set by converter control bits 2:0; the serial port has its own rate field.
// [R10] Core frame rate has a four-bit field; serial port rate has a three-bit field.
// [R11] Host should set converter, serial port and core rates equal unless compensating.
// [R12] Rate codes scale the base rate by 1, 1/6, 1/4, 1/3, 1/2, 1/1.5, 2.
// [R13] Host configures the PLL, integer or fractional, through the PLL control register.
// [R14] Host writes all six PLL control bytes in one uninterrupted transaction.
// [R15] PLL reference clock must lie between 11 MHz and 20 MHz.
// [R16] Integer mode multiplies by the integer ratio only, ignoring numerator and denominator.
// [R17] Fractional mode multiplies the divided reference by integer plus numerator over denominator.
// [R18] Host keeps the PLL output between 41 MHz and 54 MHz.
// [R19] Core clock stays off while locking; only clock and PLL registers reachable until ready.
// [R20] PLL lock is reported in bit 1 of the PLL control register.
// [R21] Source and ratio changes take effect only while the core clock is disabled.
package ccr_pkg;

    // Register subaddresses on the control port.
    localparam logic [15:0] ADDR_CLOCK_CONTROL  = 16'h4000;
    localparam logic [15:0] ADDR_PLL_CONTROL    = 16'h4002;
    localparam logic [15:0] ADDR_CONV_CONTROL   = 16'h4017;
    localparam logic [15:0] ADDR_CORE_FRAME     = 16'h40EB;
    localparam logic [15:0] ADDR_SERIAL_RATE    = 16'h40F8;

    // Clock control fields.
    localparam int          CC_ENABLE_BIT       = 0;
    localparam int          CC_RATE_LSB         = 1;
    localparam int          CC_SOURCE_BIT       = 3;
    localparam logic [3:0]  CC_RESET            = 4'h0;
    localparam logic [2:0]  RATIO_PLL           = 3'h4;

    // PLL control layout, six bytes, byte 0 least significant.
    localparam int          PLL_BYTES           = 6;
    localparam logic [5:0]  PLL_ALL_BYTES       = 6'h3F;
    localparam int          PLL_ENABLE_BIT      = 0;
    localparam int          PLL_LOCK_BIT        = 1;
    localparam int          PLL_FRAC_BIT        = 2;
    localparam int          PLL_INT_LSB         = 3;
    localparam int          PLL_XDIV_LSB        = 7;
    localparam int          PLL_NUM_LSB         = 16;
    localparam int          PLL_DEN_LSB         = 32;
    localparam logic [47:0] PLL_RESET           = 48'h0000_0000_0000;

    // Rate field codes and reset values.
    localparam logic [3:0]  RATE_DIV1           = 4'h0;
    localparam logic [3:0]  RATE_DIV6           = 4'h1;
    localparam logic [3:0]  RATE_DIV4           = 4'h2;
    localparam logic [3:0]  RATE_DIV3           = 4'h3;
    localparam logic [3:0]  RATE_DIV2           = 4'h4;
    localparam logic [3:0]  RATE_DIV1P5         = 4'h5;
    localparam logic [3:0]  RATE_MUL2           = 4'h6;
    localparam int          RATE_CHANNELS       = 3;

    // Frame periods in core clock cycles; one base-rate frame is 256 core clock cycles.
    localparam logic [10:0] PER_DIV1            = 11'h100;
    localparam logic [10:0] PER_DIV6            = 11'h600;
    localparam logic [10:0] PER_DIV4            = 11'h400;
    localparam logic [10:0] PER_DIV3            = 11'h300;
    localparam logic [10:0] PER_DIV2            = 11'h200;
    localparam logic [10:0] PER_DIV1P5          = 11'h180;
    localparam logic [10:0] PER_MUL2            = 11'h080;

    // Maps a rate code to its frame period; reserved codes fall back to the base rate.
    function automatic logic [10:0] ccr_frame_period(input logic [3:0] code);
        logic [10:0] per;
        per = PER_DIV1;
        case (code)
            RATE_DIV6:   per = PER_DIV6;
            RATE_DIV4:   per = PER_DIV4;
            RATE_DIV3:   per = PER_DIV3;
            RATE_DIV2:   per = PER_DIV2;
            RATE_DIV1P5: per = PER_DIV1P5;
            RATE_MUL2:   per = PER_MUL2;
            default:     per = PER_DIV1;
        endcase
        return per;
    endfunction : ccr_frame_period

endpackage : ccr_pkg

// *** core/ccr_core_divider.sv ***
// Core clock divider: one output tick per ratio source edges.
`timescale 1ns/1ps
`default_nettype none
module ccr_core_divider
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Source edge stream and settings.
    input  wire logic       src_edge,
    input  wire logic [2:0] ratio,
    input  wire logic       run,
    // Core clock tick.
    output logic            core_tick
);

    logic [2:0] count_reg;
    logic [2:0] count_next;
    logic       tick_reg;
    logic       tick_next;

    // Count source edges; the counter is held clear while stopped so that every
    // restart begins with a full-length first period and no runt tick.
    always_comb
    begin
        count_next = count_reg;
        tick_next  = 1'b0;
        if (!run)
        begin
            count_next = 3'h0;
        end
        else if (src_edge)
        begin
            if (count_reg == ratio - 3'h1) // see [R04]
            begin
                count_next = 3'h0;
                tick_next  = 1'b1;
            end
            else
            begin
                count_next = count_reg + 3'h1;
            end
        end
    end

    // Register the divider state.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            count_reg <= 3'h0;
            tick_reg  <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tick_reg  <= tick_next;
        end
    end

    assign core_tick = tick_reg;

endmodule : ccr_core_divider
`default_nettype wire

// *** core/ccr_clock_rate_ctrl.sv ***
// Codec core clock source selection, gating and sample-rate frame generation.
`timescale 1ns/1ps
`default_nettype none
module ccr_clock_rate_ctrl
(
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Clock sources and PLL status from outside this domain.
    input  wire logic        external_clock_pin,
    input  wire logic        pll_clk_out,
    input  wire logic        pll_lock_raw,
    // Register access from the control port.
    input  wire logic [15:0] reg_addr,
    input  wire logic [2:0]  reg_byte_sel,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_xact,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    output logic             reg_refused,
    // PLL configuration toward the analog PLL.
    output logic             pll_enable,
    output logic             pll_frac_mode,
    output logic [3:0]       pll_int_ratio,
    output logic [1:0]       pll_in_div,
    output logic [15:0]      pll_numerator,
    output logic [15:0]      pll_denominator,
    // Core clock and frame ticks.
    output logic             core_clk_tick,
    output logic             core_clk_running,
    output logic             conv_frame_tick,
    output logic             serial_frame_tick,
    output logic             core_frame_tick
);

    // Input synchronisers: bit 0 external pin, bit 1 PLL clock, bit 2 lock.
    logic [2:0] sync_a_reg;
    logic [2:0] sync_b_reg;
    logic [1:0] edge_prev_reg;
    logic [2:0] sync_a_next;
    logic [2:0] sync_b_next;
    logic [1:0] edge_prev_next;
    logic       ext_edge;
    logic       pll_edge;
    logic       lock_s;

    // Register file state.
    logic [3:0]  cc_reg;
    logic [47:0] pll_reg;
    logic [47:0] stage_reg;
    logic [5:0]  seen_reg;
    logic [3:0]  conv_reg;
    logic [3:0]  frame_reg;
    logic [3:0]  serial_reg;
    logic [7:0]  rdata_reg;
    logic        rvalid_reg;
    logic        refused_reg;
    logic [3:0]  cc_next;
    logic [47:0] pll_next;
    logic [47:0] stage_next;
    logic [5:0]  seen_next;
    logic [3:0]  conv_next;
    logic [3:0]  frame_next;
    logic [3:0]  serial_next;
    logic [7:0]  rdata_next;
    logic        rvalid_next;
    logic        refused_next;
    logic        access_open;
    logic        access_ok;
    logic [47:0] pll_view;

    // Active clock configuration.
    logic        act_src_reg;
    logic [2:0]  act_ratio_reg;
    logic        run_reg;
    logic        act_src_next;
    logic [2:0]  act_ratio_next;
    logic        run_next;
    logic [2:0]  div_ratio;
    logic        src_edge;

    // Two flops per input before any logic reads it; the edge flop reads stage two only.
    always_comb
    begin
        sync_a_next    = {pll_lock_raw, pll_clk_out, external_clock_pin};
        sync_b_next    = sync_a_reg;
        edge_prev_next = sync_b_reg[1:0];
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sync_a_reg    <= 3'h0;
            sync_b_reg    <= 3'h0;
            edge_prev_reg <= 2'h0;
        end
        else
        begin
            sync_a_reg    <= sync_a_next;
            sync_b_reg    <= sync_b_next;
            edge_prev_reg <= edge_prev_next;
        end
    end

    assign ext_edge = sync_b_reg[0] & ~edge_prev_reg[0];
    assign pll_edge = sync_b_reg[1] & ~edge_prev_reg[1];
    assign lock_s   = sync_b_reg[2];

    // Only clock and PLL control are open until the core clock is enabled and the PLL reports lock.
    assign access_open = cc_reg[ccr_pkg::CC_ENABLE_BIT] & lock_s; // see [R19]
    assign access_ok   = (reg_addr == ccr_pkg::ADDR_CLOCK_CONTROL)
                       | (reg_addr == ccr_pkg::ADDR_PLL_CONTROL) | access_open;

    // Read view of the PLL register with the live lock flag in place.
    always_comb
    begin
        pll_view                        = pll_reg;
        pll_view[ccr_pkg::PLL_LOCK_BIT] = lock_s; // see [R20]
    end

    // Register writes, PLL byte staging and read data.
    always_comb
    begin
        cc_next      = cc_reg;
        pll_next     = pll_reg;
        stage_next   = stage_reg;
        seen_next    = reg_xact ? seen_reg : 6'h00;
        conv_next    = conv_reg;
        frame_next   = frame_reg;
        serial_next  = serial_reg;
        rdata_next   = rdata_reg;
        rvalid_next  = reg_rd;
        refused_next = (reg_wr | reg_rd) & ~access_ok; // see [R19]
        if (reg_wr && access_ok)
        begin
            case (reg_addr)
                ccr_pkg::ADDR_CLOCK_CONTROL: cc_next = reg_wdata[3:0]; // see [R05]
                ccr_pkg::ADDR_CONV_CONTROL:  conv_next = {1'b0, reg_wdata[2:0]}; // see [R09]
                ccr_pkg::ADDR_CORE_FRAME:    frame_next = reg_wdata[3:0]; // see [R10]
                ccr_pkg::ADDR_SERIAL_RATE:   serial_next = {1'b0, reg_wdata[2:0]}; // see [R10]
                ccr_pkg::ADDR_PLL_CONTROL:
                begin
                    if (reg_byte_sel < 3'(ccr_pkg::PLL_BYTES))
                    begin
                        stage_next[reg_byte_sel * 8 +: 8] = reg_wdata;
                        seen_next[reg_byte_sel]           = 1'b1;
                    end
                end
                default:
                begin
                    cc_next = cc_reg;
                end
            endcase
        end
        // A partial PLL write never reaches the PLL; all six bytes commit together.
        if (seen_next == ccr_pkg::PLL_ALL_BYTES)
        begin
            pll_next  = stage_next; // see [R14]
            seen_next = 6'h00;
        end
        if (reg_rd)
        begin
            case (reg_addr)
                ccr_pkg::ADDR_CLOCK_CONTROL: rdata_next = {4'h0, cc_reg};
                ccr_pkg::ADDR_CONV_CONTROL:  rdata_next = {4'h0, conv_reg};
                ccr_pkg::ADDR_CORE_FRAME:    rdata_next = {4'h0, frame_reg};
                ccr_pkg::ADDR_SERIAL_RATE:   rdata_next = {4'h0, serial_reg};
                ccr_pkg::ADDR_PLL_CONTROL:
                    rdata_next = (reg_byte_sel < 3'(ccr_pkg::PLL_BYTES))
                               ? pll_view[reg_byte_sel * 8 +: 8] : 8'h00;
                default: rdata_next = 8'h00;
            endcase
            if (!access_ok)
            begin
                rdata_next = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cc_reg      <= ccr_pkg::CC_RESET;
            pll_reg     <= ccr_pkg::PLL_RESET;
            stage_reg   <= ccr_pkg::PLL_RESET;
            seen_reg    <= 6'h00;
            conv_reg    <= ccr_pkg::RATE_DIV1;
            frame_reg   <= ccr_pkg::RATE_DIV1;
            serial_reg  <= ccr_pkg::RATE_DIV1;
            rdata_reg   <= 8'h00;
            rvalid_reg  <= 1'b0;
            refused_reg <= 1'b0;
        end
        else
        begin
            cc_reg      <= cc_next;
            pll_reg     <= pll_next;
            stage_reg   <= stage_next;
            seen_reg    <= seen_next;
            conv_reg    <= conv_next;
            frame_reg   <= frame_next;
            serial_reg  <= serial_next;
            rdata_reg   <= rdata_next;
            rvalid_reg  <= rvalid_next;
            refused_reg <= refused_next;
        end
    end

    // PLL settings; integer mode zeroes the fraction so the PLL cannot use it.
    assign pll_enable      = pll_reg[ccr_pkg::PLL_ENABLE_BIT];
    assign pll_frac_mode   = pll_reg[ccr_pkg::PLL_FRAC_BIT]; // see [R17]
    assign pll_int_ratio   = pll_reg[ccr_pkg::PLL_INT_LSB +: 4];
    assign pll_in_div      = pll_reg[ccr_pkg::PLL_XDIV_LSB +: 2];
    assign pll_numerator   = pll_frac_mode ? pll_reg[ccr_pkg::PLL_NUM_LSB +: 16] : 16'h0000; // see [R16]
    assign pll_denominator = pll_frac_mode ? pll_reg[ccr_pkg::PLL_DEN_LSB +: 16] : 16'h0000; // see [R16]

    // Source and ratio are only copied while the clock is gated off, so a change
    // written mid-run waits for the next disable rather than cutting a pulse short.
    always_comb
    begin
        act_src_next   = act_src_reg;
        act_ratio_next = act_ratio_reg;
        if (!run_reg)
        begin
            act_src_next   = cc_reg[ccr_pkg::CC_SOURCE_BIT]; // see [R21]
            act_ratio_next = {1'b0, cc_reg[ccr_pkg::CC_RATE_LSB +: 2]} + 3'h1; // see [R06]
        end
        // Enable alone is not enough on the PLL: the clock waits for lock.
        run_next = cc_reg[ccr_pkg::CC_ENABLE_BIT] & (~act_src_next | lock_s); // see [R07]
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            act_src_reg   <= 1'b0;
            act_ratio_reg <= 3'h1;
            run_reg       <= 1'b0;
        end
        else
        begin
            act_src_reg   <= act_src_next;
            act_ratio_reg <= act_ratio_next;
            run_reg       <= run_next;
        end
    end

    // PLL runs at 1024x, so it always divides by four to land on 256x.
    assign div_ratio = act_src_reg ? ccr_pkg::RATIO_PLL : act_ratio_reg; // see [R03]
    assign src_edge  = act_src_reg ? pll_edge : ext_edge; // see [R01]

    // Every source path lands on the same 256x core rate.
    ccr_core_divider u_div // see [R02]
    (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .src_edge  (src_edge),
        .ratio     (div_ratio),
        .run       (run_reg),
        .core_tick (core_clk_tick)
    );

    assign core_clk_running = run_reg;

    // Frame tick generators, all counted in core clock ticks.
    logic [3:0]  rate_code [ccr_pkg::RATE_CHANNELS];
    logic [2:0]  frame_tick;
    assign rate_code[0] = conv_reg;
    assign rate_code[1] = serial_reg;
    assign rate_code[2] = frame_reg;

    genvar gi;
    generate
        for (gi = 0; gi < ccr_pkg::RATE_CHANNELS; gi++)
        begin : g_rate
            logic [10:0] cnt_reg;
            logic [10:0] cnt_next;
            logic        tick_reg;
            logic        tick_next;

            // A new code applies to the frame in progress; counts run in core ticks.
            always_comb
            begin
                cnt_next  = cnt_reg;
                tick_next = 1'b0;
                if (!run_reg)
                begin
                    cnt_next = 11'h000;
                end
                else if (core_clk_tick) // see [R08]
                begin
                    if (cnt_reg >= ccr_pkg::ccr_frame_period(rate_code[gi]) - 11'h001) // see [R12]
                    begin
                        cnt_next  = 11'h000;
                        tick_next = 1'b1;
                    end
                    else
                    begin
                        cnt_next = cnt_reg + 11'h001;
                    end
                end
            end

            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    cnt_reg  <= 11'h000;
                    tick_reg <= 1'b0;
                end
                else
                begin
                    cnt_reg  <= cnt_next;
                    tick_reg <= tick_next;
                end
            end

            assign frame_tick[gi] = tick_reg;
        end
    endgenerate

    assign conv_frame_tick   = frame_tick[0];
    assign serial_frame_tick = frame_tick[1];
    assign core_frame_tick   = frame_tick[2];
    assign reg_rdata         = rdata_reg;
    assign reg_rvalid        = rvalid_reg;
    assign reg_refused       = refused_reg;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_wr_blocked;
        reg_wr && (reg_addr == ccr_pkg::ADDR_CONV_CONTROL) && !access_open;
    endsequence

    sequence s_pll_waiting;
        !run_reg && act_src_reg && !lock_s;
    endsequence

    chk_pll_div_four: // see [R03]
        assert property (run_reg && act_src_reg |-> div_ratio == 3'h4)
        else $error("PLL source not divided by four");
    chk_pin_div_field: // see [R04]
        assert property (run_reg && !act_src_reg |-> div_ratio == act_ratio_reg)
        else $error("pin source divider does not follow rate field");
    chk_gate_stops_tick: // see [R07]
        assert property (!cc_reg[ccr_pkg::CC_ENABLE_BIT] |-> ##2 !core_clk_tick)
        else $error("core clock ticked while disabled");
    chk_blocked_write: // see [R19]
        assert property (s_wr_blocked |=> $stable(conv_reg) && reg_refused)
        else $error("gated register write was taken");
    chk_lock_wait: // see [R19]
        assert property (s_pll_waiting ##1 (!lock_s && act_src_reg) |-> !run_reg ##1 !core_clk_tick)
        else $error("core clock started before PLL lock");
    chk_no_switch_running: // see [R21]
        assert property (run_reg ##1 run_reg |-> $stable(act_src_reg) && $stable(act_ratio_reg))
        else $error("clock source changed while running");
    chk_frame_follows_core: // see [R08]
        assert property (conv_frame_tick |-> $past(core_clk_tick))
        else $error("frame tick not derived from core tick");
    chk_lock_readback: // see [R20]
        assert property (reg_rd && reg_addr == ccr_pkg::ADDR_PLL_CONTROL && reg_byte_sel == 3'h0
                         |=> reg_rvalid && reg_rdata[ccr_pkg::PLL_LOCK_BIT] == $past(lock_s))
        else $error("lock flag not reported in PLL byte zero");
    chk_int_no_fraction: // see [R16]
        assert property (!pll_frac_mode |-> pll_numerator == 16'h0000 && pll_denominator == 16'h0000)
        else $error("integer mode passes a fraction");

endmodule : ccr_clock_rate_ctrl
`default_nettype wire

// *** testbench/ccr_clock_source_model.sv ***
// Reference clock pin and analog PLL stand-in facing the clock and rate block.
`timescale 1ns/1ps
`default_nettype none
module ccr_clock_source_model
#(
    parameter int LOCK_CYCLES = 40
)
(
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst,
    // PLL enable from the block.
    input  wire logic pll_enable,
    // Clocks and lock toward the block.
    output var logic  external_clock_pin,
    output var logic  pll_clk_out,
    output var logic  pll_lock_raw
);
    int lock_count;

    // Reference at 20 MHz, offset so that no edge meets a system clock edge.
    initial
    begin
        external_clock_pin = 1'b0;
        #2;
        forever #25 external_clock_pin = ~external_clock_pin;
    end

    // PLL output stands low while disabled; slowed to stay under half of clk_sys.
    initial
    begin
        pll_clk_out = 1'b0;
        #3;
        forever #25 pll_clk_out = pll_enable ? ~pll_clk_out : 1'b0;
    end

    // Lock comes only after a settling time and falls as soon as the PLL stops.
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst || !pll_enable)
        begin
            lock_count   <= 0;
            pll_lock_raw <= 1'b0;
        end
        else
        begin
            lock_count   <= lock_count + 1;
            pll_lock_raw <= (lock_count >= LOCK_CYCLES);
        end
    end
endmodule : ccr_clock_source_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the codec clock and rate control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // Stimulus, observed outputs and bookkeeping.
    logic        clk_sys, rst, reg_wr, reg_rd, reg_xact, reg_rvalid, reg_refused;
    logic [15:0] reg_addr, pll_numerator, pll_denominator;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [2:0]  reg_byte_sel;
    logic [3:0]  pll_int_ratio;
    logic [1:0]  pll_in_div;
    logic        pll_enable, pll_frac_mode, core_clk_tick, core_clk_running;
    logic        conv_frame_tick, serial_frame_tick, core_frame_tick;
    logic        external_clock_pin, pll_clk_out, pll_lock_raw;
    logic [4:0]  ev;
    logic [7:0]  pb [6];
    int          errors, comparisons, n;
    localparam int PER [7] = '{256, 1536, 1024, 768, 512, 384, 128};

    // Event lines; the top bit marks every cycle.
    assign ev = {1'b1, core_frame_tick, serial_frame_tick, conv_frame_tick, core_clk_tick};

    ccr_clock_rate_ctrl ccr_clock_rate_ctrl_inst (.clk_sys, .rst, .external_clock_pin,
        .pll_clk_out, .pll_lock_raw, .reg_addr, .reg_byte_sel, .reg_wr, .reg_rd, .reg_wdata,
        .reg_xact, .reg_rdata, .reg_rvalid, .reg_refused, .pll_enable, .pll_frac_mode,
        .pll_int_ratio, .pll_in_div, .pll_numerator, .pll_denominator, .core_clk_tick,
        .core_clk_running, .conv_frame_tick, .serial_frame_tick, .core_frame_tick);
    ccr_clock_source_model ccr_clock_source_model_inst (.clk_sys, .rst, .pll_enable,
        .external_clock_pin, .pll_clk_out, .pll_lock_raw);

    // System clock at 100 MHz.
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // One register access; returns where read data and refusal are settled.
    task automatic acc(input logic wr, input logic [15:0] a, input logic [2:0] s,
                       input logic [7:0] d);
        @(negedge clk_sys);
        {reg_wr, reg_rd, reg_addr, reg_byte_sel, reg_wdata} = {wr, !wr, a, s, d};
        @(negedge clk_sys);
        {reg_wr, reg_rd} = 2'b00;
    endtask : acc

    // Counts unit events u from one event t to the next, bounded.
    task automatic gap(input int t, input int u, output int cnt);
        int w;
        cnt = 0;
        w = 0;
        @(negedge clk_sys);
        while (ev[t] !== 1'b1 && w < 20000)
        begin
            @(negedge clk_sys);
            w++;
        end
        do
        begin
            @(negedge clk_sys);
            cnt += int'(ev[u] === 1'b1);
            w++;
        end
        while (ev[t] !== 1'b1 && w < 20000);
    endtask : gap

    // Writes the first cnt PLL bytes inside one transaction, then closes it.
    task automatic pll(input logic [7:0] b0, input int cnt);
        pb = '{b0, 8'h00, 8'h0C, 8'h00, 8'h7D, 8'h00};
        reg_xact = 1'b1;
        for (int i = 0; i < cnt; i++)
            acc(1'b1, 16'h4002, 3'(i), pb[i]);
        reg_xact = 1'b0;
        @(negedge clk_sys);
    endtask : pll

    task automatic s_reset();
        check("idle outputs", {core_clk_running, pll_enable, pll_numerator}, 0);
        acc(1'b0, 16'h4000, 3'h0, 8'h00);
        check("clock control", reg_rdata, 8'h00);
        acc(1'b1, 16'h4017, 3'h0, 8'h05);
        check("gated write", reg_refused, 1);
        acc(1'b0, 16'h4017, 3'h0, 8'h00);
        check("gated read", {reg_rvalid, reg_refused, reg_rdata}, 10'h300);
    endtask : s_reset

    task automatic s_pll();
        pll(8'h21, 3);
        check("partial pll", pll_enable, 0);
        pll(8'h21, 6);
        check("int pll", {pll_enable, pll_frac_mode, pll_int_ratio, pll_in_div,
              pll_numerator, pll_denominator}, 40'h90_0000_0000);
        acc(1'b1, 16'h4000, 3'h0, 8'h0F);
        repeat (20) @(negedge clk_sys);
        check("wait lock", core_clk_running, 0);
        repeat (40) @(negedge clk_sys);
        check("run locked", core_clk_running, 1);
        acc(1'b0, 16'h4002, 3'h0, 8'h00);
        check("lock bit", reg_rdata, 8'h23);
        pll(8'h25, 6);
        check("frac pll", {pll_frac_mode, pll_numerator, pll_denominator}, 33'h1_000C_007D);
    endtask : s_pll

    task automatic s_clock();
        for (int c = 0; c < 4; c++)
        begin
            acc(1'b1, 16'h4000, 3'h0, 8'h00);
            acc(1'b1, 16'h4000, 3'h0, 8'(c * 2 + 1));
            gap(0, 4, n);
            check("pin ratio", n, (c + 1) * 5);
            check("running", core_clk_running, 1);
        end
        acc(1'b1, 16'h4000, 3'h0, 8'h01);
        gap(0, 4, n);
        check("live change", n, 20);
        acc(1'b1, 16'h4000, 3'h0, 8'h00);
        repeat (3) @(negedge clk_sys);
        n = 0;
        repeat (60) @(negedge clk_sys) n += int'(core_clk_tick === 1'b1);
        check("gated ticks", n, 0);
        acc(1'b1, 16'h4000, 3'h0, 8'h0F);
        gap(0, 4, n);
        check("pll ratio", n, 20);
        acc(1'b1, 16'h4000, 3'h0, 8'h00);
        acc(1'b1, 16'h4000, 3'h0, 8'h01);
    endtask : s_clock

    task automatic s_rates();
        for (int c = 0; c < 7; c++)
        begin
            acc(1'b1, 16'h4017, 3'h0, 8'(c));
            acc(1'b1, 16'h40F8, 3'h0, 8'(c));
            acc(1'b1, 16'h40EB, 3'h0, 8'(c));
            gap(1, 0, n);
            check("conv period", n, PER[c]);
            acc(1'b0, 16'h4017, 3'h0, 8'h00);
            check("conv readback", reg_rdata, 8'(c));
        end
        gap(2, 0, n);
        check("serial period", n, 128);
        acc(1'b1, 16'h40EB, 3'h0, 8'h07);
        gap(3, 0, n);
        check("core period", n, 256);
    endtask : s_rates

    task automatic complete_run();
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // Main sequence: reset for eight cycles, then each scenario in turn.
    initial
    begin
        rst = 1'b1;
        {reg_wr, reg_rd, reg_xact, reg_addr, reg_byte_sel, reg_wdata} = '0;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        s_reset();
        s_pll();
        s_clock();
        s_rates();
        complete_run();
    end

    // Watchdog well beyond the expected run of about 50000 cycles.
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        errors++;
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
